// file: hdl/pq_irq_pkg.sv
// package: register map, field positions and event types for the power quality irq block
package pq_irq_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [15:0] phase_event_source_addr      = 16'he600;
  localparam logic [15:0] phase_noload_flags_addr      = 16'he608;
  localparam logic [15:0] interrupt_enable_second_addr = 16'he610;
  localparam logic [15:0] main_event_flags_addr        = 16'he614;
  localparam logic [15:0] variant_config_addr          = 16'he618;

  // ----------------------------------------------------------------
  // enable / status bit positions (shared layout)
  // ----------------------------------------------------------------
  localparam int total_power_idle_bit     = 0;
  localparam int fundamental_idle_bit     = 1;
  localparam int apparent_idle_bit        = 2;
  localparam int phase_c_crossing_bit     = 14;
  localparam int reset_complete_bit       = 15;
  localparam int voltage_dip_bit          = 16;
  localparam int excess_current_bit       = 17;
  localparam int excess_voltage_bit       = 18;
  localparam int phase_order_error_bit    = 19;
  localparam int neutral_disagree_bit     = 20;
  localparam int current_peak_period_bit  = 23;
  localparam int voltage_peak_period_bit  = 24;

  // writable bits of the enable register; reserved 13:3, 22:21 and 31:25 stay zero
  localparam logic [31:0] enable_writable_mask = 32'h019f_c007;
  localparam logic [31:0] enable_reset_value   = 32'h0000_0000;

  // ----------------------------------------------------------------
  // phase event source field positions
  // ----------------------------------------------------------------
  localparam int excess_current_phase_lsb = 3;
  localparam int excess_voltage_phase_lsb = 9;
  localparam int voltage_dip_phase_lsb    = 12;

  // ----------------------------------------------------------------
  // no-load field positions
  // ----------------------------------------------------------------
  localparam int total_power_idle_lsb = 0;
  localparam int fundamental_idle_lsb = 3;
  localparam int apparent_idle_lsb    = 6;

  localparam logic [15:0] reg16_reset_value = 16'h0000;
  localparam logic [31:0] reg32_reset_value = 32'h0000_0000;

  // ----------------------------------------------------------------
  // grouped carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] current_crossing;  // per-phase current zero crossing strobes, c is bit 2
    logic [2:0] voltage_rise;      // rising voltage zero crossing strobes a,b,c
    logic [2:0] excess_current;    // per-phase overcurrent strobes
    logic [2:0] excess_voltage;    // per-phase overvoltage strobes
    logic [2:0] voltage_dip;       // per-phase sag strobes
    logic       reset_done;        // reset-complete strobe
    logic       current_peak_end;  // current peak period ended
    logic       voltage_peak_end;  // voltage peak period ended
  } event_in_t;

  typedef struct packed {
    logic [2:0] total_power;
    logic [2:0] fundamental;
    logic [2:0] apparent;
  } noload_in_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_t;

  typedef enum logic [1:0] {
    seq_idle   = 2'b00,
    seq_wait_b = 2'b01
  } seq_state_t;

endpackage

// file: hdl/power_quality_irq_status.sv
// power quality interrupt enable, main status and per-phase status registers
// Operation
// - phase C current crossing interrupts when enabled
// - bit 15 writable, reset-complete always signalled
// - sag interrupt; phases logged in bits 14:12
// - overcurrent interrupt; phases logged in bits 5:3
// - overvoltage interrupt; phases logged in bits 11:9
// - A rise followed by C rise flags error
// - neutral mismatch above threshold interrupts; variant gated
// - current peak period end interrupts when enabled
// - voltage peak period end interrupts when enabled
// - reserved enable bits read zero, no function
// - reserved phase and no-load bits read zero
// - overcurrent phase bits 3..5 per phase
// - overvoltage phase bits 9..11 per phase
// - sag phase bits 12..14 per phase
// - no-load bits 0..2 from total power
// - bits 3..5 fundamental, zero without fundamental
// - no-load bits 6..8 from apparent power
`timescale 1ns/10ps
module power_quality_irq_status
  import pq_irq_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        srst,
  // register port
  input  wire bus_req_t    bus_req,
  output logic      [31:0] bus_rdata,
  // measurement events
  input  wire event_in_t   events,
  input  wire noload_in_t  noload,
  input  wire logic [23:0] summed_phase_current,
  input  wire logic [23:0] neutral_current_sample,
  input  wire logic        mismatch_sample_valid,
  // interrupt
  output logic             irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [31:0] interrupt_enable_second;
  logic [31:0] main_event_flags;
  logic [15:0] phase_event_source;
  logic [15:0] phase_noload_flags;
  logic [23:0] mismatch_threshold;
  logic        has_neutral;
  logic        has_fundamental;
  seq_state_t  seq_state;
  seq_state_t  next_seq_state;
  logic        seq_error;
  logic        mismatch_hit;
  logic [31:0] event_set;
  logic [31:0] read_clear;
  logic [2:0]  total_power_idle_phase;
  logic [2:0]  fundamental_idle_phase;
  logic [2:0]  apparent_idle_phase;

  function automatic logic [23:0] magnitude(input logic [23:0] v);
    magnitude = v[23] ? 24'(-v) : v;
  endfunction

  function automatic logic hit(input logic [15:0] a, input logic [15:0] b);
    hit = (a == b);
  endfunction

  // ----------------------------------------------------------------
  // writable registers
  // ----------------------------------------------------------------
  // bit 15 stores but steers nothing; reserved bits never stored
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      interrupt_enable_second <= enable_reset_value;
    end else if (bus_req.wr && hit(bus_req.addr, interrupt_enable_second_addr)) begin
      interrupt_enable_second <= bus_req.wdata & enable_writable_mask;
    end
  end

  // threshold and variant straps are software settings
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      mismatch_threshold <= 24'h00_0000;
      has_neutral        <= 1'b1;
      has_fundamental    <= 1'b1;
    end else if (bus_req.wr && hit(bus_req.addr, variant_config_addr)) begin
      mismatch_threshold <= bus_req.wdata[23:0];
      has_neutral        <= bus_req.wdata[24];
      has_fundamental    <= bus_req.wdata[25];
    end
  end

  // ----------------------------------------------------------------
  // phase order check
  // ----------------------------------------------------------------
  // after an A rise, the next rise seen must be B; a C rise first is an error
  always_comb begin
    next_seq_state = seq_state;
    seq_error      = 1'b0;
    case (seq_state)
      seq_idle: begin
        if (events.voltage_rise[0]) begin
          next_seq_state = seq_wait_b;
        end
      end
      seq_wait_b: begin
        if (events.voltage_rise[2] && !events.voltage_rise[1]) begin
          seq_error      = 1'b1;
          next_seq_state = events.voltage_rise[0] ? seq_wait_b : seq_idle;
        end else if (events.voltage_rise[1]) begin
          next_seq_state = events.voltage_rise[0] ? seq_wait_b : seq_idle;
        end
      end
      default: begin
        next_seq_state = seq_idle;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      seq_state <= seq_idle;
    end else begin
      seq_state <= next_seq_state;
    end
  end

  // ----------------------------------------------------------------
  // neutral mismatch
  // ----------------------------------------------------------------
  logic [23:0] abs_sum;
  logic [23:0] abs_neutral;
  logic [23:0] diff_mag;
  always_comb begin
    abs_sum      = magnitude(summed_phase_current);
    abs_neutral  = magnitude(neutral_current_sample);
    diff_mag     = (abs_sum >= abs_neutral) ? abs_sum - abs_neutral : abs_neutral - abs_sum;
    mismatch_hit = mismatch_sample_valid && has_neutral && (diff_mag > mismatch_threshold);
  end

  // ----------------------------------------------------------------
  // main status flags
  // ----------------------------------------------------------------
  assign fundamental_idle_phase = has_fundamental ? noload.fundamental : 3'b000;
  assign total_power_idle_phase = noload.total_power;
  assign apparent_idle_phase    = noload.apparent;

  always_comb begin
    event_set = 32'h0000_0000;
    event_set[total_power_idle_bit]    = |(total_power_idle_phase & ~phase_noload_flags[2:0]);
    event_set[fundamental_idle_bit]    = |(fundamental_idle_phase & ~phase_noload_flags[5:3]);
    event_set[apparent_idle_bit]       = |(apparent_idle_phase & ~phase_noload_flags[8:6]);
    event_set[phase_c_crossing_bit]    = events.current_crossing[2];
    event_set[reset_complete_bit]      = events.reset_done;
    event_set[voltage_dip_bit]         = |events.voltage_dip;
    event_set[excess_current_bit]      = |events.excess_current;
    event_set[excess_voltage_bit]      = |events.excess_voltage;
    event_set[phase_order_error_bit]   = seq_error;
    event_set[neutral_disagree_bit]    = mismatch_hit;
    event_set[current_peak_period_bit] = events.current_peak_end;
    event_set[voltage_peak_period_bit] = events.voltage_peak_end;
  end

  assign read_clear = (bus_req.rd && hit(bus_req.addr, main_event_flags_addr)) ?
                      32'hffff_ffff : 32'h0000_0000;

  // set wins over the read clear
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      main_event_flags <= reg32_reset_value;
    end else begin
      main_event_flags <= (main_event_flags & ~read_clear) | event_set;
    end
  end

  // ----------------------------------------------------------------
  // phase event source: sticky per phase, cleared on read
  // ----------------------------------------------------------------
  logic phase_read;
  assign phase_read = bus_req.rd && hit(bus_req.addr, phase_event_source_addr);

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      phase_event_source <= reg16_reset_value;
    end else begin
      phase_event_source <= (phase_read ? 16'h0000 : phase_event_source)
        | {1'b0, events.voltage_dip, events.excess_voltage, 3'b000,
           events.excess_current, 3'b000};
    end
  end

  // ----------------------------------------------------------------
  // no-load: live per-phase state
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      phase_noload_flags <= reg16_reset_value;
    end else begin
      phase_noload_flags <= {7'h00, apparent_idle_phase, fundamental_idle_phase,
                             total_power_idle_phase};
    end
  end

  // ----------------------------------------------------------------
  // interrupt output
  // ----------------------------------------------------------------
  // reset-complete cannot be masked, so it bypasses the enable
  logic [31:0] live_enable;
  always_comb begin
    live_enable = interrupt_enable_second;
    live_enable[reset_complete_bit] = 1'b1;
    live_enable[neutral_disagree_bit] = interrupt_enable_second[neutral_disagree_bit] && has_neutral;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((main_event_flags & ~read_clear) | event_set) & live_enable);
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      bus_rdata <= reg32_reset_value;
    end else if (bus_req.rd) begin
      case (bus_req.addr)
        phase_event_source_addr:      bus_rdata <= {16'h0000, phase_event_source};
        phase_noload_flags_addr:      bus_rdata <= {16'h0000, phase_noload_flags};
        interrupt_enable_second_addr: bus_rdata <= interrupt_enable_second;
        main_event_flags_addr:        bus_rdata <= main_event_flags;
        variant_config_addr: begin
          bus_rdata <= {6'h00, has_fundamental, has_neutral, mismatch_threshold};
        end
        default:                      bus_rdata <= 32'h0000_0000;
      endcase
    end else begin
      bus_rdata <= 32'h0000_0000;
    end
  end

endmodule

// file: bench/pq_irq_props.sv
// checker: port-level properties of the power quality irq block
`timescale 1ns/10ps
module pq_irq_props
  import pq_irq_pkg::*;
(
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        srst,
  // register port
  input wire bus_req_t    bus_req,
  input wire logic [31:0] bus_rdata,
  // measurement side
  input wire event_in_t   events,
  input wire noload_in_t  noload,
  input wire logic [23:0] summed_phase_current,
  input wire logic [23:0] neutral_current_sample,
  input wire logic        mismatch_sample_valid,
  input wire logic        irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  logic rd_ph;
  logic rd_nl;
  logic rd_st;
  assign rd_ph = bus_req.rd && bus_req.addr == phase_event_source_addr;
  assign rd_nl = bus_req.rd && bus_req.addr == phase_noload_flags_addr;
  assign rd_st = bus_req.rd && bus_req.addr == main_event_flags_addr;
  // ------
  // properties
  // ------
  a_rdata_idle: assert property (!$past(bus_req.rd) |-> bus_rdata == 32'h0)
    else $error("read data outside read slot");
  a_phase_rsvd: assert property ($past(rd_ph) |-> (bus_rdata & 32'hffff_81c7) == 32'h0)
    else $error("phase source reserved bits set");
  a_noload_rsvd: assert property ($past(rd_nl) |-> bus_rdata[31:9] == 23'h0)
    else $error("no-load reserved bits set");
  a_noload_live: assert property (rd_nl && $stable(noload) && noload == $past(noload, 2) |=>
    bus_rdata[2:0] == $past(noload.total_power) && bus_rdata[8:6] == $past(noload.apparent))
    else $error("no-load flags do not follow inputs");
  a_dip_phase: assert property (events.voltage_dip != 3'h0 ##2 rd_ph |=>
    (bus_rdata[14:12] & $past(events.voltage_dip, 3)) == $past(events.voltage_dip, 3))
    else $error("sag phase not logged");
  a_cur_phase: assert property (events.excess_current != 3'h0 ##2 rd_ph |=>
    (bus_rdata[5:3] & $past(events.excess_current, 3)) == $past(events.excess_current, 3))
    else $error("overcurrent phase not logged");
  a_volt_phase: assert property (events.excess_voltage != 3'h0 ##2 rd_ph |=>
    (bus_rdata[11:9] & $past(events.excess_voltage, 3)) == $past(events.excess_voltage, 3))
    else $error("overvoltage phase not logged");
  a_done_irq: assert property (events.reset_done |=> irq)
    else $error("reset-complete did not interrupt");
  a_crossing_flag: assert property (events.current_crossing[2] ##2 rd_st |=> bus_rdata[14])
    else $error("phase c crossing flag missing");
  // a write to the enable reaches the registered irq one edge later than a read clear
  a_irq_fall: assert property ($fell(irq) |-> $past(rd_st) || $past(bus_req.wr, 2))
    else $error("irq dropped without clear or write");
  c_done: cover property (events.reset_done ##1 irq);
  c_status: cover property (rd_st ##1 bus_rdata != 32'h0);
  c_noload: cover property (rd_nl ##1 bus_rdata != 32'h0);
endmodule
bind power_quality_irq_status pq_irq_props u_props (
  .sys_clk(sys_clk), .srst(srst), .bus_req(bus_req), .bus_rdata(bus_rdata),
  .events(events), .noload(noload), .summed_phase_current(summed_phase_current),
  .neutral_current_sample(neutral_current_sample),
  .mismatch_sample_valid(mismatch_sample_valid), .irq(irq));

// file: bench/power_quality_irq_status_tb.sv
// testbench: registers, events and interrupt of the power quality irq block
`timescale 1ns/10ps
module power_quality_irq_status_tb import pq_irq_pkg::*;;
  logic        sys_clk = 1'b0;
  logic        srst = 1'b1;
  bus_req_t    bus_req = '0;
  logic [31:0] bus_rdata;
  event_in_t   events = '0;
  noload_in_t  noload = '0;
  logic [23:0] summed_phase_current = '0;
  logic [23:0] neutral_current_sample = '0;
  logic        mismatch_sample_valid = 1'b0;
  logic        irq;
  logic        rd_seen = 1'b0;
  int          errors = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  int          pos[8] = '{14, 15, 16, 17, 18, 23, 24, 14};
  logic [31:0] exp_q[$];
  always #12.5 sys_clk = ~sys_clk;
  power_quality_irq_status dut (
    .sys_clk(sys_clk), .srst(srst), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .events(events), .noload(noload), .summed_phase_current(summed_phase_current),
    .neutral_current_sample(neutral_current_sample),
    .mismatch_sample_valid(mismatch_sample_valid), .irq(irq));
  // ------
  // tasks
  // ------
  task automatic final_report();
    if (errors == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one request, then an idle cycle so no signal is driven twice in a step
  task automatic op(logic [15:0] a, logic [31:0] d, logic w, logic r);
    bus_req <= '{a, d, w, r};
    @(posedge sys_clk);
    bus_req <= '0;
    @(posedge sys_clk);
  endtask
  task automatic rd(logic [15:0] a, logic [31:0] e);
    exp_q.push_back(e);
    op(a, 32'h0, 1'b0, 1'b1);
  endtask
  task automatic pulse(event_in_t e, logic x);
    events <= e;
    @(posedge sys_clk);
    events <= '0;
    @(posedge sys_clk);
    check("irq", {31'h0, irq}, {31'h0, x});
  endtask
  // extra idle cycle before the irq check; the magnitude compare is combinational and needs none
  task automatic mis(int s, int n, logic x);
    summed_phase_current <= 24'(s);
    neutral_current_sample <= 24'(n);
    mismatch_sample_valid <= 1'b1;
    @(posedge sys_clk);
    mismatch_sample_valid <= 1'b0;
    repeat (2) @(posedge sys_clk);
    check("irq", {31'h0, irq}, {31'h0, x});
    rd(main_event_flags_addr, {11'h0, x, 20'h0});
  endtask
  // ------
  // monitor and timeout
  // ------
  always @(posedge sys_clk) begin
    if (rd_seen) check("rdata", bus_rdata, exp_q.pop_front());
    rd_seen <= bus_req.rd;
    cyc++;
    if (cyc == 3000) begin
      errors++;
      final_report();
    end
  end
  initial begin
    logic [31:0] a;
    logic [2:0]  ph;
    int          p;
    event_in_t   ev;
    noload_in_t  nl;
    a = $urandom(32'hfef8b9ee);
    repeat (10) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    for (int k = 0; k < 18; k++) begin
      a = 32'he600 + 32'(4 * (k % 6));
      if (k < 6 || k > 11) begin
        rd(a[15:0], (k > 11 && a[15:0] == 16'he610) ? enable_writable_mask : 32'h0);
      end else begin
        op(a[15:0], 32'hffff_ffff, 1'b1, 1'b0);
      end
    end
    for (int i = 0; i < 8; i++) begin
      ev = '0;
      ph = 3'($urandom_range(7, 1));
      case (i)
        0: ev.current_crossing = 3'b100;
        1: ev.reset_done = 1'b1;
        2: ev.voltage_dip = ph;
        3: ev.excess_current = ph;
        4: ev.excess_voltage = ph;
        5: ev.current_peak_end = 1'b1;
        6: ev.voltage_peak_end = 1'b1;
        default: ev.current_crossing = 3'b011;
      endcase
      p = i == 2 ? 12 : i == 3 ? 3 : 9;
      for (int en = 0; en < 2; en++) begin
        op(interrupt_enable_second_addr, en ? 32'h1 << pos[i] : 32'h0, 1'b1, 1'b0);
        pulse(ev, (en == 1 || i == 1) && i < 7);
        if (i inside {[2:4]}) rd(phase_event_source_addr, 32'(ph) << p);
        rd(main_event_flags_addr, i < 7 ? 32'h1 << pos[i] : 32'h0);
        check("irq", {31'h0, irq}, 32'h0);
      end
    end
    op(interrupt_enable_second_addr, 32'h0008_0000, 1'b1, 1'b0);
    pulse(event_in_t'(18'h01000), 1'b0);
    pulse(event_in_t'(18'h04000), 1'b1);
    rd(main_event_flags_addr, 32'h0008_0000);
    pulse(event_in_t'(18'h01000), 1'b0);
    pulse(event_in_t'(18'h02000), 1'b0);
    pulse(event_in_t'(18'h04000), 1'b0);
    rd(main_event_flags_addr, 32'h0);
    op(interrupt_enable_second_addr, 32'h0010_0000, 1'b1, 1'b0);
    op(variant_config_addr, 32'h0300_000a, 1'b1, 1'b0);
    p = $urandom_range(900, 100);
    mis(p, 15 - p, 1'b1);
    mis(100, 95, 1'b0);
    mis(-100, 90, 1'b0);
    mis(-100, 89, 1'b1);
    op(variant_config_addr, 32'h0200_000a, 1'b1, 1'b0);
    mis(100, -85, 1'b0);
    nl = noload_in_t'($urandom_range(511, 1));
    noload <= nl;
    repeat (3) @(posedge sys_clk);
    rd(phase_noload_flags_addr, 32'({nl.apparent, nl.fundamental, nl.total_power}));
    rd(main_event_flags_addr, 32'({|nl.apparent, |nl.fundamental, |nl.total_power}));
    op(variant_config_addr, 32'h0100_000a, 1'b1, 1'b0);
    rd(phase_noload_flags_addr, 32'({nl.apparent, 3'h0, nl.total_power}));
    final_report();
  end
endmodule
